// file: design/uec_pkg.sv
// Shared constants for the serial responder with baud calibration
package uec_pkg;

  // ==========================================================================
  // Clocks and rates
  localparam int unsigned REF_CLK_HZ    = 20_000_000;
  localparam int unsigned SLOW_OSC_HZ   = 4_000_000;
  localparam int unsigned MCK_HZ        = SLOW_OSC_HZ / 2;
  localparam int unsigned BAUD_BPS      = 9600;
  localparam int unsigned OSC_STAB_NS   = 100_000;
  localparam int unsigned OSC_STAB_CYC  = (OSC_STAB_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;

  // ==========================================================================
  // Serial framing and divisor
  localparam int unsigned FRAME_BITS    = 11;
  localparam logic [6:0]  SER_DIV_RST   = 7'(MCK_HZ / (2 * BAUD_BPS) - 1);
  localparam logic [6:0]  SER_DIV_MAX   = 7'h7f;
  localparam logic [15:0] CAL_NUMERATOR = 16'h5ac0;

  // ==========================================================================
  // Timers
  localparam logic [5:0]  INT_PRESC_MAX = 6'h3f;
  localparam logic [7:0]  INT_COMPARE   = 8'he9;
  localparam logic [15:0] DIV_RELOAD    = 16'h1295;
  localparam logic [1:0]  MEAS_NEEDED   = 2'h2;

  // ==========================================================================
  // Reply characters
  localparam logic [7:0]  CH_T_UP = 8'h54;
  localparam logic [7:0]  CH_T_LO = 8'h74;
  localparam logic [7:0]  CH_O_UP = 8'h4f;
  localparam logic [7:0]  CH_K_UP = 8'h4b;
  localparam logic [7:0]  CH_O_LO = 8'h6f;
  localparam logic [7:0]  CH_K_LO = 8'h6b;
  localparam logic [7:0]  CH_U_UP = 8'h55;
  localparam logic [7:0]  CH_C_UP = 8'h43;
  localparam logic [7:0]  CH_P_UP = 8'h50;
  localparam logic [7:0]  CH_E_UP = 8'h45;
  localparam logic [7:0]  CH_F_UP = 8'h46;
  localparam logic [7:0]  CH_CR   = 8'h0d;
  localparam logic [7:0]  CH_LF   = 8'h0a;

  typedef enum logic [2:0] {
    RSP_OK_UP, RSP_OK_LO, RSP_UC, RSP_PE, RSP_FE, RSP_OE
  } uec_rsp_t;

  typedef enum logic [3:0] {
    CAL_IDLE = 4'b0001,
    CAL_STAB = 4'b0010,
    CAL_MEAS = 4'b0100,
    CAL_REST = 4'b1000
  } uec_cal_t;

endpackage : uec_pkg

// file: design/uec_top.sv
// Serial responder with oscillator-based baud calibration, plus its reply FIFO
//
// Behaviour
// - Good byte T answers 4F 4B 0D 0A.
// - Good byte t answers 6F 6B 0D 0A.
// - Any other good byte answers 55 43 0D 0A.
// - Parity error answers 50 45 0D 0A.
// - Framing error answers 46 45 0D 0A.
// - Overrun error answers 4F 45 0D 0A.
// - Frames carry 8 data bits LSB first, even parity, normal levels.
// - Both ends run at 9600 bits per second nominal.
// - Separate rx-done, tx-done and rx-error events; only rx ones drive replies.
// - 8-bit interval counter at source/64, compare E9, raises calibration tick.
// - Divider: 16-bit timer on slow oscillator, toggles wave, no start event.
// - Measuring counter on fast oscillator; each rising input edge captures and restarts.
// - Divider reload is 4757, half period is reload plus one counts.
// - Division factor keeps measured count within 16 bits.
// - Calibration: LED on, serial off, fast osc on, settle, switch, time, await two.
// - After second capture: stop timers, new divisor, slow clock, osc off, serial on.
// - New divisor is 23232 over the upper eight capture bits, capped at 127.
// - Serial clock is slow clock over 2; divisor+1 is that over 2*9600.
// - Interval counter holds while a reply is in progress.
// - Other wake causes leave the responder idle with no action.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Reply FIFO
module uec_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk,   // Clock
  input  wire logic             reset,     // Async reset, high
  input  wire logic             ce,        // Clock enable
  input  wire logic             in_valid,  // Write request
  output var  logic             in_ready,  // Space available
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  output var  logic             out_valid, // Data available
  input  wire logic             out_ready, // Read accept
  output var  logic [WIDTH-1:0] out_data   // Read data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } uec_fifo_st_t;
  uec_fifo_st_t st_ff, nxt_st;
  logic push, pop;

  assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data  = st_ff.mem[st_ff.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = (st_ff.wp == AW'(DEPTH-1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == AW'(DEPTH-1)) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end
endmodule : uec_fifo

// ============================================================================
// Responder top
module uec_top
  import uec_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic       ref_clk,                // 20 MHz clock
  input  wire logic       reset,                  // Async reset, high
  input  wire logic       ce,                     // Clock enable, freezes all state
  input  wire logic       slow_osc_tick,          // One-cycle strobe per slow oscillator cycle
  input  wire logic       fast_osc_tick,          // One-cycle strobe per fast oscillator cycle
  input  wire logic       interval_src_tick,      // Interval counter source strobe
  input  wire logic       serial_in,              // Receive pin
  input  wire logic       measure_input,          // Measuring pin
  output var  logic       serial_out,             // Transmit pin
  output var  logic       divided_wave_output,    // Divided square wave pin
  output var  logic       cal_led,                // Calibration indicator
  output var  logic       fast_osc_en,            // Fast oscillator run request
  output var  logic       sys_clk_fast_sel,       // System clock on fast oscillator
  output var  logic       serial_enable,          // Serial channels running
  output var  logic [6:0] serial_divisor,         // Divisor field, bits 15:9 of divisor reg
  output var  logic       rx_complete_event,      // Good byte received pulse
  output var  logic       tx_complete_event,      // Byte sent pulse
  output var  logic       rx_error_event,         // Errored reception pulse
  output var  logic       calibration_tick_event  // Interval compare pulse
);
  typedef struct packed {
    logic [1:0]  rx_sync;
    logic        rx_last;
    logic [1:0]  meas_sync;
    logic        meas_last;
    logic        mck_ph;
    logic        rx_busy;
    logic [8:0]  rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_data;
    logic        rx_par;
    logic        rx_fe;
    logic        hold_v;
    uec_rsp_t    hold_kind;
    logic        load_busy;
    uec_rsp_t    load_kind;
    logic [1:0]  load_idx;
    logic        tx_busy;
    logic [8:0]  tx_cnt;
    logic [3:0]  tx_bit;
    logic [10:0] tx_shift;
    logic        tx_line;
    logic [5:0]  int_presc;
    logic [7:0]  int_cnt;
    uec_cal_t    cal;
    logic [11:0] stab_cnt;
    logic        div_run;
    logic [15:0] div_cnt;
    logic        wave;
    logic        meas_run;
    logic [15:0] meas_cnt;
    logic [15:0] meas_cap;
    logic [1:0]  meas_n;
    logic        led;
    logic        fosc;
    logic        sys_fast;
    logic        ser_en;
    logic [6:0]  divisor;
    logic        ev_rx;
    logic        ev_tx;
    logic        ev_err;
    logic        ev_cal;
  } uec_st_t;

  localparam uec_st_t ST_RST = '{rx_sync: 2'h3, rx_last: 1'b1, meas_sync: 2'h0,
    meas_last: 1'b0, mck_ph: 1'b0,
    rx_busy: 1'b0, rx_cnt: '0, rx_bit: '0, rx_data: '0, rx_par: 1'b0, rx_fe: 1'b0, hold_v: 1'b0,
    hold_kind: RSP_UC, load_busy: 1'b0, load_kind: RSP_UC, load_idx: '0, tx_busy: 1'b0, tx_cnt: '0,
    tx_bit: '0, tx_shift: '1, tx_line: 1'b1, int_presc: '0, int_cnt: '0, cal: CAL_IDLE, stab_cnt: '0,
    div_run: 1'b0, div_cnt: '0, wave: 1'b0, meas_run: 1'b0, meas_cnt: '0, meas_cap: '0, meas_n: '0,
    led: 1'b0, fosc: 1'b0, sys_fast: 1'b0, ser_en: 1'b1, divisor: SER_DIV_RST, ev_rx: 1'b0,
    ev_tx: 1'b0, ev_err: 1'b0, ev_cal: 1'b0};

  uec_st_t st_ff, nxt_st;

  logic       fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_in_data, fifo_out_data;
  logic       mck_tick, reply_busy, rx_done, rx_err;
  logic [8:0] half_bit, full_bit;
  logic [7:0] cap_hi;
  logic [15:0] quot;

  // ==========================================================================
  // Reply table
  function automatic logic [7:0] reply_byte(input uec_rsp_t kind, input logic [1:0] idx);
    logic [7:0] b;
    b = CH_LF;
    unique case (idx)
      2'd0: begin
        unique case (kind)
          RSP_OK_UP: b = CH_O_UP;
          RSP_OK_LO: b = CH_O_LO;
          RSP_UC:    b = CH_U_UP;
          RSP_PE:    b = CH_P_UP;
          RSP_FE:    b = CH_F_UP;
          default:   b = CH_O_UP;
        endcase
      end
      2'd1: begin
        unique case (kind)
          RSP_OK_UP: b = CH_K_UP;
          RSP_OK_LO: b = CH_K_LO;
          RSP_UC:    b = CH_C_UP;
          default:   b = CH_E_UP;
        endcase
      end
      2'd2: b = CH_CR;
      2'd3: b = CH_LF;
    endcase
    return b;
  endfunction : reply_byte

  // ==========================================================================
  // Shared combinational terms
  assign mck_tick       = slow_osc_tick && st_ff.mck_ph;
  assign half_bit       = {2'b00, st_ff.divisor};
  assign full_bit       = {1'b0, st_ff.divisor, 1'b1};
  assign rx_done        = st_ff.rx_busy && mck_tick && st_ff.rx_cnt == '0 && st_ff.rx_bit == 4'd10;
  assign rx_err         = st_ff.rx_par || !st_ff.rx_sync[1];
  assign reply_busy     = st_ff.hold_v || st_ff.load_busy || fifo_out_valid || st_ff.tx_busy;
  assign fifo_in_valid  = st_ff.load_busy;
  assign fifo_in_data   = reply_byte(st_ff.load_kind, st_ff.load_idx);
  assign fifo_out_ready = st_ff.ser_en && !st_ff.tx_busy;
  assign cap_hi         = st_ff.meas_cap[15:8];
  // Divide by zero cannot happen on a sane wave; guarded anyway to keep the old divisor
  assign quot           = (cap_hi == '0) ? 16'(st_ff.divisor) : CAL_NUMERATOR / 16'(cap_hi);

  uec_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .ce        (ce),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.ev_rx     = 1'b0;
    nxt_st.ev_tx     = 1'b0;
    nxt_st.ev_err    = 1'b0;
    nxt_st.ev_cal    = 1'b0;
    nxt_st.rx_sync   = {st_ff.rx_sync[0], serial_in};
    nxt_st.meas_sync = {st_ff.meas_sync[0], measure_input};
    nxt_st.meas_last = st_ff.meas_sync[1];
    nxt_st.rx_last   = st_ff.rx_sync[1];
    if (slow_osc_tick) begin
      nxt_st.mck_ph = !st_ff.mck_ph;
    end

    // Receiver: samples mid-bit, counts in serial clock ticks
    if (!st_ff.ser_en) begin
      nxt_st.rx_busy = 1'b0;
    end else if (!st_ff.rx_busy) begin
      // Falling edge only: a stop bit still low after a framing error must not restart
      if (!st_ff.rx_sync[1] && st_ff.rx_last) begin
        nxt_st.rx_busy = 1'b1;
        nxt_st.rx_cnt  = half_bit;
        nxt_st.rx_bit  = '0;
        nxt_st.rx_par  = 1'b0;
      end
    end else if (mck_tick) begin
      if (st_ff.rx_cnt != '0) begin
        nxt_st.rx_cnt = st_ff.rx_cnt - 1'b1;
      end else begin
        nxt_st.rx_cnt = full_bit;
        nxt_st.rx_bit = st_ff.rx_bit + 1'b1;
        if (st_ff.rx_bit == '0 && st_ff.rx_sync[1]) begin
          nxt_st.rx_busy = 1'b0;                               // Glitch, not a start bit
        end
        if (st_ff.rx_bit >= 4'd1 && st_ff.rx_bit <= 4'd8) begin
          nxt_st.rx_data = {st_ff.rx_sync[1], st_ff.rx_data[7:1]};
        end
        if (st_ff.rx_bit >= 4'd1 && st_ff.rx_bit <= 4'd9) begin
          nxt_st.rx_par = st_ff.rx_par ^ st_ff.rx_sync[1];
        end
        if (rx_done) begin
          nxt_st.rx_busy = 1'b0;
        end
      end
    end

    // Loader takes the held reply; set wins over take
    if (!st_ff.load_busy && st_ff.hold_v) begin
      nxt_st.load_busy = 1'b1;
      nxt_st.load_kind = st_ff.hold_kind;
      nxt_st.load_idx  = '0;
      nxt_st.hold_v    = 1'b0;
    end else if (st_ff.load_busy && fifo_in_ready) begin
      nxt_st.load_idx = st_ff.load_idx + 1'b1;
      if (st_ff.load_idx == 2'd3) begin
        nxt_st.load_busy = 1'b0;
      end
    end
    if (rx_done) begin
      nxt_st.hold_v = 1'b1;
      nxt_st.ev_rx  = !rx_err;
      nxt_st.ev_err = rx_err;
      if (st_ff.hold_v && !(!st_ff.load_busy)) begin
        nxt_st.hold_kind = RSP_OE;
        nxt_st.ev_rx     = 1'b0;
        nxt_st.ev_err    = 1'b1;
      end else if (!st_ff.rx_sync[1]) begin
        nxt_st.hold_kind = RSP_FE;
      end else if (st_ff.rx_par) begin
        nxt_st.hold_kind = RSP_PE;
      end else if (st_ff.rx_data == CH_T_UP) begin
        nxt_st.hold_kind = RSP_OK_UP;
      end else if (st_ff.rx_data == CH_T_LO) begin
        nxt_st.hold_kind = RSP_OK_LO;
      end else begin
        nxt_st.hold_kind = RSP_UC;
      end
    end

    // Transmitter: start, 8 data LSB first, even parity, stop
    if (fifo_out_valid && fifo_out_ready) begin
      nxt_st.tx_busy  = 1'b1;
      nxt_st.tx_shift = {1'b1, ^fifo_out_data, fifo_out_data, 1'b0};
      nxt_st.tx_bit   = '0;
      nxt_st.tx_cnt   = full_bit;
    end else if (st_ff.tx_busy && mck_tick) begin
      if (st_ff.tx_cnt != '0) begin
        nxt_st.tx_cnt = st_ff.tx_cnt - 1'b1;
      end else begin
        nxt_st.tx_cnt   = full_bit;
        nxt_st.tx_shift = {1'b1, st_ff.tx_shift[10:1]};
        nxt_st.tx_bit   = st_ff.tx_bit + 1'b1;
        if (st_ff.tx_bit == 4'(FRAME_BITS - 1)) begin
          nxt_st.tx_busy = 1'b0;
          nxt_st.ev_tx   = 1'b1;
        end
      end
    end
    nxt_st.tx_line = nxt_st.tx_busy ? nxt_st.tx_shift[0] : 1'b1;

    // Interval counter, held during a reply or calibration
    if (interval_src_tick && !reply_busy && st_ff.cal == CAL_IDLE) begin
      nxt_st.int_presc = st_ff.int_presc + 1'b1;
      if (st_ff.int_presc == INT_PRESC_MAX) begin
        nxt_st.int_cnt = st_ff.int_cnt + 1'b1;
        if (st_ff.int_cnt == INT_COMPARE) begin
          nxt_st.int_cnt = '0;
          nxt_st.ev_cal  = 1'b1;
        end
      end
    end

    // Divider channel, started low with no event
    if (st_ff.div_run && slow_osc_tick) begin
      if (st_ff.div_cnt == '0) begin
        nxt_st.div_cnt = DIV_RELOAD;
        nxt_st.wave    = !st_ff.wave;
      end else begin
        nxt_st.div_cnt = st_ff.div_cnt - 1'b1;
      end
    end

    // Measuring channel: the first capture is partial, the second is a full period
    if (st_ff.meas_run) begin
      if (fast_osc_tick) begin
        nxt_st.meas_cnt = st_ff.meas_cnt + 1'b1;
      end
      if (st_ff.meas_sync[1] && !st_ff.meas_last) begin
        nxt_st.meas_cap = st_ff.meas_cnt;
        nxt_st.meas_cnt = '0;
        nxt_st.meas_n   = st_ff.meas_n + 1'b1;
      end
    end

    // Calibration sequence; other causes never leave idle
    unique case (st_ff.cal)
      CAL_IDLE: begin
        if (st_ff.ev_cal) begin
          nxt_st.led      = 1'b1;
          nxt_st.ser_en   = 1'b0;
          nxt_st.fosc     = 1'b1;
          nxt_st.stab_cnt = 12'(OSC_STAB_CYC - 1);
          nxt_st.cal      = CAL_STAB;
        end
      end
      CAL_STAB: begin
        nxt_st.stab_cnt = st_ff.stab_cnt - 1'b1;
        if (st_ff.stab_cnt == '0) begin
          nxt_st.sys_fast = 1'b1;
          nxt_st.div_run  = 1'b1;
          nxt_st.div_cnt  = DIV_RELOAD;
          nxt_st.wave     = 1'b0;
          nxt_st.meas_run = 1'b1;
          nxt_st.meas_cnt = '0;
          nxt_st.meas_n   = '0;
          nxt_st.cal      = CAL_MEAS;
        end
      end
      CAL_MEAS: begin
        if (st_ff.meas_n == MEAS_NEEDED) begin
          nxt_st.div_run  = 1'b0;
          nxt_st.meas_run = 1'b0;
          nxt_st.wave     = 1'b0;
          nxt_st.divisor  = (quot > 16'(SER_DIV_MAX)) ? SER_DIV_MAX : quot[6:0];
          nxt_st.sys_fast = 1'b0;
          nxt_st.cal      = CAL_REST;
        end
      end
      CAL_REST: begin
        nxt_st.fosc   = 1'b0;
        nxt_st.ser_en = 1'b1;
        nxt_st.led    = 1'b0;
        nxt_st.cal    = CAL_IDLE;
      end
      default: nxt_st = ST_RST;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= ST_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign serial_out             = st_ff.tx_line;
  assign divided_wave_output    = st_ff.wave;
  assign cal_led                = st_ff.led;
  assign fast_osc_en            = st_ff.fosc;
  assign sys_clk_fast_sel       = st_ff.sys_fast;
  assign serial_enable          = st_ff.ser_en;
  assign serial_divisor         = st_ff.divisor;
  assign rx_complete_event      = st_ff.ev_rx;
  assign tx_complete_event      = st_ff.ev_tx;
  assign rx_error_event         = st_ff.ev_err;
  assign calibration_tick_event = st_ff.ev_cal;

  // ==========================================================================
  // Checks
  property p_ok_up;
    @(posedge ref_clk) disable iff (reset)
    (st_ff.load_busy && st_ff.load_kind == RSP_OK_UP && st_ff.load_idx == 2'd0) |-> fifo_in_data == CH_O_UP;
  endproperty
  a_ok_up: assert property (p_ok_up) else $error("T reply must start with O");

  property p_ok_lo;
    @(posedge ref_clk) disable iff (reset)
    (st_ff.load_busy && st_ff.load_kind == RSP_OK_LO && st_ff.load_idx == 2'd1) |-> fifo_in_data == CH_K_LO;
  endproperty
  a_ok_lo: assert property (p_ok_lo) else $error("t reply second byte must be k");

  property p_err_only;
    @(posedge ref_clk) disable iff (reset)
    rx_error_event |-> !rx_complete_event && st_ff.hold_kind inside {RSP_PE, RSP_FE, RSP_OE};
  endproperty
  a_err_only: assert property (p_err_only) else $error("Errored byte also flagged as data");

  property p_int_hold;
    @(posedge ref_clk) disable iff (reset)
    (ce && reply_busy) |=> $stable(st_ff.int_cnt) && !calibration_tick_event;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("Interval counter moved during reply");

  property p_wave_toggle;
    @(posedge ref_clk) disable iff (reset)
    (ce && st_ff.div_run && slow_osc_tick && st_ff.div_cnt == '0)
      |=> divided_wave_output != $past(divided_wave_output) && st_ff.div_cnt == DIV_RELOAD;
  endproperty
  a_wave_toggle: assert property (p_wave_toggle) else $error("Divider failed to toggle and reload");

  property p_meas_state;
    @(posedge ref_clk) disable iff (reset)
    st_ff.cal == CAL_MEAS |-> !serial_enable && fast_osc_en && sys_clk_fast_sel && cal_led;
  endproperty
  a_meas_state: assert property (p_meas_state) else $error("Measurement without proper clock setup");

  property p_restore;
    @(posedge ref_clk) disable iff (reset)
    (ce && st_ff.cal == CAL_REST) |-> !sys_clk_fast_sel ##1 (serial_enable && !cal_led && !fast_osc_en);
  endproperty
  a_restore: assert property (p_restore) else $error("Restore order broken");

  property p_capture;
    @(posedge ref_clk) disable iff (reset)
    (ce && st_ff.meas_run && st_ff.meas_sync[1] && !st_ff.meas_last)
      |=> st_ff.meas_cap == $past(st_ff.meas_cnt) && st_ff.meas_cnt == '0;
  endproperty
  a_capture: assert property (p_capture) else $error("Edge did not capture and restart");

endmodule : uec_top

`default_nettype wire

// file: dv/uec_peer.sv
// Far-side serial device model for the responder bench
`timescale 1ns/1ps
`default_nettype none
module uec_peer #(
  parameter int BIT = 416 // Ref cycles per bit
) (
  input  wire logic ref_clk,  // Clock
  output var  logic line_out, // To receive pin
  input  wire logic line_in   // From transmit pin
);
  logic [8:0]  rx_q[$];
  logic [10:0] fr;
  logic [10:0] rv;
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    fr = {~bad_stop, ^d ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge ref_clk) line_out = fr[i];
      repeat (BIT - 1) @(negedge ref_clk);
    end
    line_out = 1'b1;
  endtask : send
  // ==========
  // Mid-bit sampler; bit 8 flags a clean even-parity frame
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      if (i > 0) repeat (BIT) @(posedge ref_clk);
      rv[i] = line_in;
    end
    rx_q.push_back({~rv[0] & rv[10] & ~^rv[9:1], rv[8:1]});
  end
endmodule : uec_peer
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the serial responder
`timescale 1ns/1ps
`default_nettype none
module tb_top import uec_pkg::*;;
  localparam int BIT = 416;
  localparam int LIM = 40000;
  localparam int HI = 2 * (4757 + 1) / 256;
  localparam int EXD = 23232 / HI > 127 ? 127 : 23232 / HI; // Field saturates at 7 bits
  localparam logic [7:0] TXB [5] = '{8'h54, 8'h74, 8'h00, 8'h54, 8'hff};
  localparam logic [31:0] RSP [5] = '{32'h4f4b_0d0a, 32'h6f6b_0d0a, 32'h5543_0d0a, 32'h5045_0d0a, 32'h4645_0d0a};
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic       ft = 1'b0;
  logic       ce = 1'b1;
  logic [8:0] r;
  logic [7:0] eb;
  wire  logic si, so, wv, led, fen, fs, se, rc, tc, re, ct;
  wire  logic [6:0] sd;
  int bad_count = 0, compares = 0, nrc = 0, nre = 0, ntc = 0, nct = 0, k;
  always #25 ref_clk = ~ref_clk;
  always @(negedge ref_clk) ft <= fen;
  // Pulses are counted away from the edge that launches them
  always @(negedge ref_clk) begin
    nrc += int'(rc);
    nre += int'(re);
    ntc += int'(tc);
    nct += int'(ct);
  end
  uec_top u_uec_top (.ref_clk(ref_clk), .reset(reset), .ce(ce), .slow_osc_tick(1'b1),
    .fast_osc_tick(ft), .interval_src_tick(1'b1), .serial_in(si), .measure_input(wv),
    .serial_out(so), .divided_wave_output(wv), .cal_led(led), .fast_osc_en(fen),
    .sys_clk_fast_sel(fs), .serial_enable(se), .serial_divisor(sd), .rx_complete_event(rc),
    .tx_complete_event(tc), .rx_error_event(re), .calibration_tick_event(ct));
  uec_peer #(.BIT(BIT)) u_uec_peer (.ref_clk(ref_clk), .line_out(si), .line_in(so));
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic tmo(input string n);
    if (k >= LIM) begin
      bad_count++;
      $display("mismatch %s expected done seen timeout", n);
      conclude();
    end
  endtask : tmo
  task automatic conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // ==========
  // Next byte overlaps the reply, so the interval counter stays held mid-run
  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    cmp("div", 16'(sd), 16'(2_000_000 / (2 * 9600) - 1));
    for (int i = 0; i < 6; i++) begin
      if (i < 5) u_uec_peer.send(TXB[i], i == 3, i == 4);
      for (k = 0; k < LIM && u_uec_peer.rx_q.size() < (i < 5 ? 4 * i + 2 : 20); k++) @(negedge ref_clk);
      tmo("reply");
    end
    for (int i = 0; i < 20; i++) begin
      r = u_uec_peer.rx_q[i];
      eb = RSP[i / 4][31 - 8 * (i % 4) -: 8];
      cmp("frame", 16'(r[8]), 16'h0001);
      cmp("byte", 16'(r[7:0]), 16'(eb));
    end
    for (k = 0; k < LIM && led !== 1'b1; k++) @(negedge ref_clk);
    tmo("cal");
    cmp("cal", 16'({se, fen, fs}), 16'h0002);
    // Frozen cycles must not shorten the settle count
    ce = 1'b0;
    repeat (100) @(negedge ref_clk);
    ce = 1'b1;
    for (k = 0; k < 3000 && fs !== 1'b1; k++) @(negedge ref_clk);
    cmp("settle", 16'(k), 16'(OSC_STAB_CYC));
    for (k = 0; k < LIM && led !== 1'b0; k++) @(negedge ref_clk);
    tmo("end");
    cmp("end", 16'({se, fen, fs, wv}), 16'h0008);
    cmp("newdiv", 16'(sd), 16'(EXD));
    cmp("rxc", 16'(nrc), 16'h0003);
    cmp("rxe", 16'(nre), 16'h0002);
    cmp("txc", 16'(ntc), 16'h0014);
    cmp("calt", 16'(nct), 16'h0001);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
